// file: logic/sseq_defines.svh
// Purpose: shared constants for the step attribute editor
// Assumes: 25 MHz system clock
// Notes:   included by its bare name
`ifndef SSEQ_DEFINES_SVH
`define SSEQ_DEFINES_SVH

// ----------------------------------------------------------------
// step storage
// ----------------------------------------------------------------
`define SSEQ_STEPS        16
`define SSEQ_STEP_W       4
`define SSEQ_LAST_STEP    4'hF
`define SSEQ_SECT_W       2
`define SSEQ_OFS_MIN      (-8'sd64)
`define SSEQ_OFS_MAX      (8'sd48)
`define SSEQ_OFS_ZERO     8'h00
`define SSEQ_GRP_SIZE     16
`define SSEQ_GRP_SHIFT    4
`define SSEQ_GATE_DEF     2'h2
`define SSEQ_VEL_ACCENT   7'h3F

// ----------------------------------------------------------------
// controller mapping: zero offset gives 78, offsets map to 14..126
// ----------------------------------------------------------------
`define SSEQ_CC_ZERO      8'sd78
`define SSEQ_CC_MIN       7'h0D
`define SSEQ_CC_MAX       7'h7E

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSEQ_CLK_HZ       25000000
`define SSEQ_DBL_MS       300
`define SSEQ_DBL_CYC      ((`SSEQ_CLK_HZ / 1000) * `SSEQ_DBL_MS)
`define SSEQ_BLINK_CYC    4000000
`define SSEQ_CNT_W        24
`define SSEQ_PWM_W        3

// ----------------------------------------------------------------
// register map (byte addresses are index times four)
// ----------------------------------------------------------------
`define SSEQ_A_CTRL       4'h0
`define SSEQ_A_STATUS     4'h1
`define SSEQ_A_STEPSEL    4'h2
`define SSEQ_A_STEPDAT    4'h3
`define SSEQ_A_CCOUT      4'h4

`endif

// file: logic/sseq_pkg.sv
// Purpose: types for the step attribute editor
// Assumes: nothing
// Notes:   state codes follow a Gray sequence in declaration order, normal to record
package sseq_pkg;

	typedef enum logic [2:0] {
		SSEQ_NORMAL = 3'h0,
		SSEQ_CUTOFF = 3'h1,
		SSEQ_PITCH  = 3'h3,
		SSEQ_TIME   = 3'h2,
		SSEQ_REC    = 3'h6
	} sseq_mode_t;

	typedef enum logic [1:0] {
		SSEQ_T_REST = 2'h0,
		SSEQ_T_NOTE = 2'h1,
		SSEQ_T_TIE  = 2'h2
	} sseq_time_t;

endpackage : sseq_pkg

// file: logic/sseq_dblpress.sv
// Purpose: single/double press classifier for one key group
// Assumes: press inputs are one-cycle pulses
// Notes:   single is reported only after the window runs out
`timescale 1ns/100ps
`default_nettype none
`include "sseq_defines.svh"
module sseq_dblpress
	import sseq_pkg::*;
#(
	parameter int unsigned WINDOW_CYC = `SSEQ_DBL_CYC
) (
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	// key presses
	input  wire logic [3:0] press_in,
	// classified result
	output logic            single_out,
	output logic            double_out,
	output logic [1:0]      key_out
);
	default clocking cb_sys @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	logic [`SSEQ_CNT_W-1:0] win_r;
	logic                   pend_r;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			win_r      <= '0;
			pend_r     <= 1'b0;
			key_out    <= 2'h0;
			single_out <= 1'b0;
			double_out <= 1'b0;
		end else begin
			single_out <= 1'b0;
			double_out <= 1'b0;
			if (press_in != 4'h0) begin
				// second press of same key inside window
				if (pend_r && press_in[key_out]) begin
					double_out <= 1'b1;
					pend_r     <= 1'b0;
				end else begin
					pend_r  <= 1'b1;
					win_r   <= '0;
					key_out <= press_in[0] ? 2'h0 : press_in[1] ? 2'h1 :
						press_in[2] ? 2'h2 : 2'h3;
				end
			end else if (pend_r) begin
				if (win_r == WINDOW_CYC[`SSEQ_CNT_W-1:0] - 1'b1) begin
					single_out <= 1'b1;
					pend_r     <= 1'b0;
				end
				win_r <= win_r + 1'b1;
			end
		end
	end

	property p_dbl_in_window;
		double_out |-> $past(pend_r);
	endproperty
	a_dbl_in_window: assert property (p_dbl_in_window)
		else $error("double press outside window");
endmodule : sseq_dblpress
`default_nettype wire

// file: logic/sseq_ofsdisp.sv
// Purpose: cutoff offset to group/value LED pattern
// Assumes: offset within -64..+48
// Notes:   registered outputs, one cycle latency
`timescale 1ns/100ps
`default_nettype none
`include "sseq_defines.svh"
module sseq_ofsdisp
	import sseq_pkg::*;
(
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	// offset
	input  wire logic signed [7:0] ofs_in,
	input  wire logic              blink_in,
	// leds
	output logic [3:0]             grp_led_out,
	output logic [7:0]             val_led_out
);
	default clocking cb_sys @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	logic [6:0] mag;
	logic [5:0] idx;
	logic [1:0] grp;
	logic [3:0] pos;

	always_comb begin
		mag = ofs_in[7] ? 7'(-ofs_in) : ofs_in[6:0];
		idx = 6'(mag - 7'h1);
		grp = idx[5:4];
		pos = idx[3:0];
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			grp_led_out <= 4'h1;
			val_led_out <= 8'h00;
		end else if (mag == 7'h0) begin
			grp_led_out <= 4'h1;
			val_led_out <= 8'h00;
		end else begin
			// two values per led, filled bar
			val_led_out <= 8'((9'h2 << pos[3:1]) - 9'h1);
			if (ofs_in[7])
				// negative: descending from group four, blinking
				grp_led_out <= blink_in ? 4'h0 : 4'(4'h8 >> grp);
			else
				grp_led_out <= 4'(4'h1 << grp);
		end
	end

	property p_zero_disp;
		(ofs_in == 8'sd0) |=> (grp_led_out == 4'h1 && val_led_out == 8'h00);
	endproperty
	a_zero_disp: assert property (p_zero_disp)
		else $error("zero offset display wrong");
	property p_pos32;
		(ofs_in == 8'sd32) |=> (grp_led_out == 4'h2 && val_led_out == 8'hFF);
	endproperty
	a_pos32: assert property (p_pos32)
		else $error("plus 32 display wrong");
	property p_neg1;
		(ofs_in == -8'sd1 && !blink_in) |=> (grp_led_out == 4'h8);
	endproperty
	a_neg1: assert property (p_neg1)
		else $error("first negative group wrong");
endmodule : sseq_ofsdisp
`default_nettype wire

// file: logic/sseq_editor.sv
// Purpose: per-step attribute editor and panel display for a step sequencer
// Assumes: key inputs are one-cycle press pulses unless named _held
// Notes:   registers over classic Wishbone; see tags below
//
// Behaviour
// - four group LEDs, each sixteen offset values; value LEDs give position
// - group LED steady for positive offsets, blinking for negative
// - zero offset: group one steady, value LEDs all dark
// - value LEDs fill progressively, two values per LED
// - positive 1-16 group one, 17-32 group two, 33-48 group three
// - negative descending from blinking group four; sixty-four values
// - step held in offset mode: next adds one, back subtracts one
// - group key single press positive group, double press negative
// - zero offset is controller 74 value 78; range 14 to 126
// - clear in offset mode zeroes every step's offset
// - four gate lengths 10/30/50/90 percent, default 50
// - step held plus function plus group key n sets gate n
// - step press toggles note and rest; LED lit for note
// - held step plus later step ties between; tied LEDs half bright
// - inactive steps skipped; active view lights only active steps
// - pitch entry stores pitch, advances cursor; current LED blinks
// - pitch entry exits after last step or on home
// - time entry stores note/tie/rest, advances, exits after last
// - entry cursor crossing a section boundary changes displayed section
// - record mode blinks home LED; home returns to normal
// - key held across steps recorded as one note of that length
// - MIDI velocity above 63 sets accent
// - MIDI legato note sets slide
// - offset stored as signed value from -64 to +48
`timescale 1ns/100ps
`default_nettype none
`include "sseq_defines.svh"
module sseq_editor
	import sseq_pkg::*;
(
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [5:2]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	// front panel keys
	input  wire logic [15:0] step_press_in,
	input  wire logic [15:0] step_held_in,
	input  wire logic [3:0]  group_press_in,
	input  wire logic        function_held_in,
	input  wire logic        active_view_held_in,
	input  wire logic        cutoff_offset_mode_key,
	input  wire logic        next_in,
	input  wire logic        back_in,
	input  wire logic        clear_in,
	input  wire logic        home_in,
	input  wire logic        pitch_dbl_in,
	input  wire logic        time_dbl_in,
	input  wire logic        record_in,
	input  wire logic        note_key_in,
	input  wire logic        tie_key_in,
	input  wire logic        rest_key_in,
	input  wire logic [3:0]  kbd_pitch_in,
	input  wire logic        kbd_press_in,
	input  wire logic        kbd_held_in,
	// playback and midi
	input  wire logic        step_tick_in,
	input  wire logic        midi_on_in,
	input  wire logic        midi_off_in,
	input  wire logic [6:0]  midi_vel_in,
	input  wire logic [3:0]  midi_pitch_in,
	// leds and outputs
	output logic [15:0]      step_led_out,
	output logic [3:0]       grp_led_out,
	output logic [7:0]       val_led_out,
	output logic             home_led_out,
	output logic [1:0]       section_out,
	output logic [3:0]       play_step_out,
	output logic [6:0]       cc74_out
);
	default clocking cb_sys @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	// ----------------------------------------------------------------
	// step storage
	// ----------------------------------------------------------------
	logic signed [7:0] ofs_mem   [`SSEQ_STEPS];
	logic [1:0]        gate_mem  [`SSEQ_STEPS];
	sseq_time_t        time_mem  [`SSEQ_STEPS];
	logic [3:0]        pitch_mem [`SSEQ_STEPS];
	logic [15:0]       active_r;
	logic [15:0]       accent_r;
	logic [15:0]       slide_r;

	sseq_mode_t        mode_r;
	logic [3:0]        cursor_r;
	logic [3:0]        edit_step_r;
	logic              edit_valid_r;
	logic [3:0]        play_r;
	logic [1:0]        section_r;
	logic [`SSEQ_CNT_W-1:0] blink_cnt_r;
	logic              blink_r;
	logic [`SSEQ_PWM_W-1:0] pwm_r;
	logic              rec_hold_r;
	logic              midi_hold_r;
	logic              wb_fire;
	logic [1:0]        dbl_key;
	logic              dbl_single;
	logic              dbl_double;
	logic [3:0]        ctrl_r;

	function automatic logic [3:0] first_set(input logic [15:0] v);
		logic [3:0] i;
		i = 4'h0;
		for (int k = 15; k >= 0; k--)
			if (v[k])
				i = 4'(k);
		return i;
	endfunction : first_set

	function automatic logic signed [7:0] clamp_ofs(input logic signed [8:0] v);
		if (v > 9'sd48)
			return `SSEQ_OFS_MAX;
		if (v < -9'sd64)
			return `SSEQ_OFS_MIN;
		return 8'(v);
	endfunction : clamp_ofs

	function automatic logic [3:0] next_active(input logic [3:0] s,
	                                           input logic [15:0] act);
		logic [3:0] n;
		n = s;
		for (int k = 0; k < 16; k++) begin
			n = n + 4'h1;
			if (act[n])
				break;
		end
		return n;
	endfunction : next_active

	// ----------------------------------------------------------------
	// blink and dim timebase
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
			pwm_r       <= '0;
		end else begin
			pwm_r <= pwm_r + 1'b1;
			if (blink_cnt_r == `SSEQ_CNT_W'(`SSEQ_BLINK_CYC - 1)) begin
				blink_cnt_r <= '0;
				blink_r     <= ~blink_r;
			end else
				blink_cnt_r <= blink_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// group key classifier
	// ----------------------------------------------------------------
	sseq_dblpress u_dbl (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.press_in   (group_press_in),
		.single_out (dbl_single),
		.double_out (dbl_double),
		.key_out    (dbl_key)
	);

	// ----------------------------------------------------------------
	// mode control
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mode_r   <= SSEQ_NORMAL;
			cursor_r <= 4'h0;
		end else begin
			unique case (mode_r)
				SSEQ_NORMAL: begin
					cursor_r <= 4'h0;
					if (cutoff_offset_mode_key && function_held_in)
						mode_r <= SSEQ_CUTOFF;
					else if (pitch_dbl_in)
						mode_r <= SSEQ_PITCH;
					else if (time_dbl_in)
						mode_r <= SSEQ_TIME;
					else if (record_in)
						mode_r <= SSEQ_REC;
				end
				SSEQ_CUTOFF, SSEQ_REC: begin
					if (home_in)
						mode_r <= SSEQ_NORMAL;
				end
				SSEQ_PITCH, SSEQ_TIME: begin
					if (home_in)
						mode_r <= SSEQ_NORMAL;
					else if ((mode_r == SSEQ_PITCH && kbd_press_in) ||
					         (mode_r == SSEQ_TIME &&
					          (note_key_in || tie_key_in || rest_key_in))) begin
						if (cursor_r == `SSEQ_LAST_STEP)
							mode_r <= SSEQ_NORMAL;
						cursor_r <= cursor_r + 4'h1;
					end else if (next_in)
						cursor_r <= cursor_r + 4'h1;
					else if (back_in)
						cursor_r <= cursor_r - 4'h1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// step editing
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			edit_step_r  <= 4'h0;
			edit_valid_r <= 1'b0;
			for (int k = 0; k < 16; k++) begin
				ofs_mem[k]   <= `SSEQ_OFS_ZERO;
				gate_mem[k]  <= `SSEQ_GATE_DEF;
				time_mem[k]  <= SSEQ_T_REST;
				pitch_mem[k] <= 4'h0;
			end
		end else begin
			edit_valid_r <= step_held_in != 16'h0;
			if (step_held_in != 16'h0)
				edit_step_r <= first_set(step_held_in);
			if (mode_r == SSEQ_CUTOFF) begin
				if (clear_in)
					for (int k = 0; k < 16; k++)
						ofs_mem[k] <= `SSEQ_OFS_ZERO;
				else if (edit_valid_r && next_in)
					ofs_mem[edit_step_r] <= clamp_ofs(9'(ofs_mem[edit_step_r]) + 9'sd1);
				else if (edit_valid_r && back_in)
					ofs_mem[edit_step_r] <= clamp_ofs(9'(ofs_mem[edit_step_r]) - 9'sd1);
				else if (edit_valid_r && dbl_single)
					ofs_mem[edit_step_r] <= clamp_ofs(9'({dbl_key, 4'h0}) + 9'sd1);
				else if (edit_valid_r && dbl_double)
					ofs_mem[edit_step_r] <= clamp_ofs(-9'({dbl_key, 4'h0}) - 9'sd1);
			end else if (mode_r == SSEQ_NORMAL) begin
				if (edit_valid_r && function_held_in && group_press_in != 4'h0)
					gate_mem[edit_step_r] <= 2'(first_set({12'h0, group_press_in}));
				else if (step_press_in != 16'h0 && !active_view_held_in) begin
					if (edit_valid_r && first_set(step_press_in) > edit_step_r) begin
						for (int k = 0; k < 16; k++)
							if (4'(k) > edit_step_r && 4'(k) <= first_set(step_press_in))
								time_mem[k] <= SSEQ_T_TIE;
					end else
						time_mem[first_set(step_press_in)] <=
							(time_mem[first_set(step_press_in)] == SSEQ_T_NOTE) ?
							SSEQ_T_REST : SSEQ_T_NOTE;
				end
			end else if (mode_r == SSEQ_PITCH && kbd_press_in)
				pitch_mem[cursor_r] <= kbd_pitch_in;
			else if (mode_r == SSEQ_TIME)
				time_mem[cursor_r] <= note_key_in ? SSEQ_T_NOTE :
					tie_key_in ? SSEQ_T_TIE :
					rest_key_in ? SSEQ_T_REST : time_mem[cursor_r];
			else if (mode_r == SSEQ_REC && step_tick_in) begin
				// holding keeps the note going as ties
				if (kbd_held_in && rec_hold_r || midi_hold_r)
					time_mem[next_active(play_r, active_r)] <= SSEQ_T_TIE;
				if (kbd_press_in) begin
					time_mem[next_active(play_r, active_r)]  <= SSEQ_T_NOTE;
					pitch_mem[next_active(play_r, active_r)] <= kbd_pitch_in;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// record from midi, active steps, playback
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			accent_r    <= 16'h0;
			slide_r     <= 16'h0;
			midi_hold_r <= 1'b0;
			rec_hold_r  <= 1'b0;
		end else begin
			rec_hold_r <= kbd_held_in;
			if (midi_on_in)
				midi_hold_r <= 1'b1;
			else if (midi_off_in)
				midi_hold_r <= 1'b0;
			if (mode_r == SSEQ_REC && midi_on_in) begin
				accent_r[play_r] <= midi_vel_in > `SSEQ_VEL_ACCENT;
				slide_r[play_r]  <= midi_hold_r;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			active_r <= 16'hFFFF;
			play_r   <= 4'h0;
		end else begin
			if (active_view_held_in && step_press_in != 16'h0)
				active_r <= active_r ^ step_press_in;
			if (step_tick_in)
				play_r <= next_active(play_r, active_r);
		end
	end

	// ----------------------------------------------------------------
	// display
	// ----------------------------------------------------------------
	sseq_ofsdisp u_disp (
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.ofs_in      (ofs_mem[edit_step_r]),
		.blink_in    (blink_r),
		.grp_led_out (grp_led_out),
		.val_led_out (val_led_out)
	);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			step_led_out  <= 16'h0;
			home_led_out  <= 1'b1;
			section_r     <= 2'h0;
			play_step_out <= 4'h0;
			cc74_out      <= 7'(`SSEQ_CC_ZERO);
		end else begin
			play_step_out <= play_r;
			cc74_out <= 7'(`SSEQ_CC_ZERO + 8'(ofs_mem[play_r]));
			home_led_out <= (mode_r == SSEQ_REC) ? blink_r : 1'b1;
			if (mode_r == SSEQ_PITCH || mode_r == SSEQ_TIME)
				section_r <= cursor_r[3:2];
			for (int k = 0; k < 16; k++) begin
				if (active_view_held_in)
					step_led_out[k] <= active_r[k];
				else if ((mode_r == SSEQ_PITCH || mode_r == SSEQ_TIME) &&
				         4'(k) == cursor_r)
					step_led_out[k] <= blink_r;
				else if (time_mem[k] == SSEQ_T_TIE)
					step_led_out[k] <= pwm_r[0];
				else
					step_led_out[k] <= time_mem[k] == SSEQ_T_NOTE;
			end
		end
	end
	assign section_out = section_r;

	// ----------------------------------------------------------------
	// wishbone slave: registered ack one cycle after strobe, dropped next cycle
	// ----------------------------------------------------------------
	assign wb_fire = wb_cyc_in && wb_stb_in && !wb_ack_out;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0;
			ctrl_r     <= 4'h0;
		end else begin
			wb_ack_out <= wb_fire;
			if (wb_fire && wb_we_in && wb_adr_in == `SSEQ_A_CTRL && wb_sel_in[0])
				ctrl_r <= wb_dat_in[3:0];
			if (wb_fire && !wb_we_in)
				unique case (wb_adr_in)
					`SSEQ_A_CTRL:    wb_dat_out <= {28'h0, ctrl_r};
					`SSEQ_A_STATUS:  wb_dat_out <= {25'h0, mode_r, cursor_r};
					// held step's gate and pitch ride above the mask
					`SSEQ_A_STEPSEL: wb_dat_out <= {10'h0,
						gate_mem[edit_step_r], pitch_mem[edit_step_r],
						active_r};
					`SSEQ_A_STEPDAT: wb_dat_out <= {slide_r, accent_r};
					`SSEQ_A_CCOUT:   wb_dat_out <= {25'h0, cc74_out};
					default:         wb_dat_out <= 32'h0;
				endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_clear_all;
		(mode_r == SSEQ_CUTOFF && clear_in)
		|=> (ofs_mem[0] == 8'sd0 && ofs_mem[15] == 8'sd0);
	endproperty
	a_clear_all: assert property (p_clear_all)
		else $error("clear left offsets");
	property p_pitch_exit;
		(mode_r == SSEQ_PITCH && cursor_r == 4'hF && kbd_press_in && !home_in)
		|=> mode_r == SSEQ_NORMAL;
	endproperty
	a_pitch_exit: assert property (p_pitch_exit)
		else $error("pitch entry did not exit");
	property p_home_rec;
		(mode_r == SSEQ_REC && home_in) |=> mode_r == SSEQ_NORMAL;
	endproperty
	a_home_rec: assert property (p_home_rec)
		else $error("home did not leave record");
	property p_accent;
		(mode_r == SSEQ_REC && midi_on_in && midi_vel_in == 7'h40)
		|=> accent_r[$past(play_r)];
	endproperty
	a_accent: assert property (p_accent)
		else $error("accent not set above 63");
	property p_cc_zero;
		(ofs_mem[play_r] == 8'sd0) |=> cc74_out == 7'h4E;
	endproperty
	a_cc_zero: assert property (p_cc_zero)
		else $error("zero offset not 78");
	property p_ofs_range;
		ofs_mem[edit_step_r] <= 8'sd48 && ofs_mem[edit_step_r] >= -8'sd64;
	endproperty
	a_ofs_range: assert property (p_ofs_range)
		else $error("offset out of range");
	property p_ack_once;
		wb_ack_out |=> !wb_ack_out;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack held two cycles");
	c_pitch: cover property (@(posedge clock_in) mode_r == SSEQ_PITCH);
	c_time: cover property (@(posedge clock_in) mode_r == SSEQ_TIME);
	c_rec: cover property (@(posedge clock_in) mode_r == SSEQ_REC && midi_on_in);
	c_neg: cover property (@(posedge clock_in) dbl_double);
endmodule : sseq_editor
`default_nettype wire

// file: dv/sseq_panel_model.sv
// Purpose: front panel step key model
// Assumes: bench raises tap and hold on rising edges
// Notes:   clean keys; one press pulse per tap, no bounce
`timescale 1ns/100ps
`default_nettype none
module sseq_panel_model (
	// clock
	input  wire logic        clock_in,
	// bench requests
	input  wire logic        tap_in,
	input  wire logic [3:0]  key_in,
	input  wire logic        hold_in,
	// panel lines
	output logic [15:0]      step_press_out,
	output logic [15:0]      step_held_out
);
	logic tap_r;
	// a long tap still gives a single press, as a real key scan does
	always_ff @(posedge clock_in) begin
		tap_r <= tap_in;
		step_press_out <= (tap_in && !tap_r) ? (16'h0001 << key_in) : 16'h0000;
	end
	assign step_held_out = hold_in ? (16'h0001 << key_in) : 16'h0000;
endmodule : sseq_panel_model
`default_nettype wire

// file: dv/sseq_editor_tb.sv
// Purpose: self-checking bench for the step attribute editor
// Assumes: 25 MHz clock, reset held six cycles
// Notes:   blink and double-press windows are too long to reach here
`timescale 1ns/100ps
`default_nettype none
module sseq_editor_tb;
	import sseq_pkg::*;
	logic        clock_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, hled;
	logic        tap = 1'b0, hold = 1'b0, fn = 1'b0, okey = 1'b0;
	logic        nxt = 1'b0, bck = 1'b0, clr = 1'b0, home = 1'b0, rec = 1'b0;
	logic [3:0]  adr = 4'h0, key = 4'h0, grp, pstep;
	logic [3:0]  gkey = 4'h0;
	logic        pdbl = 1'b0, kpr = 1'b0, mon = 1'b0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic [15:0] press, held, sled, idle = 16'h0000;
	logic [7:0]  vled;
	logic [6:0]  cc;
	logic [1:0]  sect;
	int          mismatches = 0, tests_run = 0;
	// ------------------------------------------------------------
	// design and panel
	// ------------------------------------------------------------
	sseq_panel_model i_panel (.clock_in(clock_in), .tap_in(tap),
		.key_in(key), .hold_in(hold), .step_press_out(press),
		.step_held_out(held));
	sseq_editor i_dut (.clock_in(clock_in), .rst_in(rst_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .step_press_in(press), .step_held_in(held),
		.group_press_in(gkey), .function_held_in(fn),
		.active_view_held_in(idle[0]), .cutoff_offset_mode_key(okey),
		.next_in(nxt), .back_in(bck), .clear_in(clr), .home_in(home),
		.pitch_dbl_in(pdbl), .time_dbl_in(idle[0]), .record_in(rec),
		.note_key_in(idle[0]), .tie_key_in(idle[0]), .rest_key_in(idle[0]),
		.kbd_pitch_in(key), .kbd_press_in(kpr),
		.kbd_held_in(idle[0]), .step_tick_in(idle[0]),
		.midi_on_in(mon), .midi_off_in(idle[0]),
		.midi_vel_in({3'h4, key}), .midi_pitch_in(idle[3:0]),
		.step_led_out(sled), .grp_led_out(grp), .val_led_out(vled),
		.home_led_out(hled), .section_out(sect), .play_step_out(pstep),
		.cc74_out(cc));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask : cmp
	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : settle
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clock_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// wait for the answer, however slow; the watchdog covers a hang
		do begin
			@(posedge clock_in);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic hit(input int s, input int n);
		repeat (n) begin
			@(posedge clock_in);
			case (s)
				0: nxt <= 1'b1;
				1: bck <= 1'b1;
				2: clr <= 1'b1;
				3: home <= 1'b1;
				4: rec <= 1'b1;
				5: okey <= 1'b1;
				7: gkey <= 4'h2;
				8: pdbl <= 1'b1;
				9: kpr <= 1'b1;
				10: mon <= 1'b1;
				default: tap <= 1'b1;
			endcase
			@(posedge clock_in);
			{nxt, bck, clr, home, rec, okey, tap, pdbl, kpr, mon} <= 10'h000;
			gkey <= 4'h0;
		end
	endtask : hit
	task automatic offset_is(input logic [3:0] g, input logic [7:0] v);
		settle(3);
		cmp("grp_led", g, grp);
		cmp("val_led", v, vled);
	endtask : offset_is
	task automatic mode_is(input sseq_mode_t m);
		settle(2);
		wb(1'b0, 4'h1, 32'h0);
		cmp("mode", m, rd[6:4]);
	endtask : mode_is
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		offset_is(4'h1, 8'h00);
		cmp("home_led", 1'b1, hled);
		cmp("cc74", 7'h4E, cc);
		wb(1'b0, 4'h2, 32'h0);
		cmp("active", 32'h0020FFFF, rd);
		cmp("play_step", 4'h0, pstep);
	endtask : t_reset
	task automatic t_toggle;
		@(posedge clock_in);
		key <= 4'h5;
		hit(6, 1);
		settle(3);
		cmp("step_led", 1'b1, sled[5]);
		hit(6, 1);
		settle(3);
		cmp("step_led", 1'b0, sled[5]);
	endtask : t_toggle
	task automatic t_offset;
		@(posedge clock_in);
		fn <= 1'b1;
		hit(5, 1);
		@(posedge clock_in);
		fn <= 1'b0;
		key <= 4'h0;
		hold <= 1'b1;
		mode_is(SSEQ_CUTOFF);
		hit(0, 3);
		offset_is(4'h1, 8'h03);
		hit(0, 29);
		offset_is(4'h2, 8'hFF);
		cmp("cc74", 7'h6E, cc);
		hit(1, 2);
		offset_is(4'h2, 8'h7F);
		hit(0, 19);
		offset_is(4'h4, 8'hFF);
		cmp("cc74", 7'h7E, cc);
		hit(1, 49);
		offset_is(4'h8, 8'h01);
		cmp("cc74", 7'h4D, cc);
		hit(1, 64);
		offset_is(4'h1, 8'hFF);
		cmp("cc74", 7'h0E, cc);
		hit(7, 2);
		offset_is(4'h4, 8'h01);
		cmp("cc74", 7'h3D, cc);
		@(posedge clock_in);
		hold <= 1'b0;
		hit(2, 1);
		offset_is(4'h1, 8'h00);
		cmp("cc74", 7'h4E, cc);
		hit(3, 1);
		mode_is(SSEQ_NORMAL);
	endtask : t_offset
	task automatic t_pitch;
		@(posedge clock_in);
		key <= 4'h9;
		hit(8, 1);
		mode_is(SSEQ_PITCH);
		hit(9, 4);
		settle(2);
		cmp("section", 2'h1, sect);
		hit(9, 12);
		mode_is(SSEQ_NORMAL);
		cmp("section", 2'h3, sect);
		@(posedge clock_in);
		hold <= 1'b1;
		fn <= 1'b1;
		settle(2);
		hit(7, 1);
		wb(1'b0, 4'h2, 32'h0);
		cmp("step_sel", 32'h0019FFFF, rd);
		hold <= 1'b0;
		fn <= 1'b0;
	endtask : t_pitch
	task automatic t_rec;
		hit(4, 1);
		mode_is(SSEQ_REC);
		key <= 4'h0;
		hit(10, 2);
		wb(1'b0, 4'h3, 32'h0);
		cmp("step_dat", 32'h00010001, rd);
		hit(3, 1);
		mode_is(SSEQ_NORMAL);
	endtask : t_rec
	task automatic t_wb;
		wb(1'b1, 4'h0, 32'h0000000A);
		wb(1'b0, 4'h0, 32'h0);
		cmp("scratch", 32'h0000000A, rd);
		wb(1'b0, 4'hF, 32'h0);
		cmp("unmapped", 32'h00000000, rd);
	endtask : t_wb
	task automatic wrap_up;
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// run
	// ------------------------------------------------------------
	initial forever #20 clock_in = ~clock_in;
	initial begin
		#400000;
		mismatches++;
		wrap_up;
	end
	initial begin
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		t_reset;
		t_toggle;
		t_offset;
		t_pitch;
		t_rec;
		t_wb;
		wrap_up;
	end
endmodule : sseq_editor_tb
`default_nettype wire
